/* File: design/lpmc_controller.sv */
// Purpose: Low-power mode sequencer with background autonomous
//          operation and an APB register slave.
// Assumes: All inputs synchronous to pclk; zero-wait APB.
// Notes:   Power controls are registered in the same cycle as state.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`include "lpmc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module lpmc_controller
    import lpmc_pkg::*;
#(
    parameter int NPERIPH = `LPMC_NPERIPH
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`LPMC_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     cpu_lp_req,
    input  wire logic                     irq_pending,
    input  wire logic                     periph_irq,
    input  wire logic [NPERIPH-1:0]       kernel_clk_req,
    input  wire logic [NPERIPH-1:0]       sys_clk_req,
    input  wire lpmc_wake_type            wake_src,
    output logic      [NPERIPH-1:0]       kernel_clk_en,
    output lpmc_pwr_type                  pwr,
    output lpmc_state_type                mode
);

    ////////////////////////////////////////////////////////////////
    // State and registers
    lpmc_state_type             state_reg;
    lpmc_state_type             state_next;
    lpmc_ctrl_type              ctrl_reg;
    lpmc_ctrl_type              ctrl_next;
    logic [`LPMC_CAUSE_W-1:0]   cause_reg;
    logic [`LPMC_CAUSE_W-1:0]   cause_next;
    lpmc_pwr_type               pwr_reg;
    lpmc_pwr_type               pwr_next;
    logic [NPERIPH-1:0]         kclk_reg;
    logic [31:0]                rdata_reg;
    logic                       wakeup_pin_prev_reg;

    localparam lpmc_pwr_type PWR_RUN = '{
        cpu_clk_en: 1'b1, core_clk_en: 1'b1, bus_clk_en: 1'b1,
        fast_internal_rc_en: 1'b1, sysclk_fast_rc: 1'b1,
        main_reg_en: 1'b1, core_supply_on: 1'b1,
        first_sram_bank_keep: 1'b1, second_sram_bank_keep: 1'b1, radio_keep: 1'b1,
        sleep_timer_en: 1'b1, default: '0};

    ////////////////////////////////////////////////////////////////
    // APB decode
    wire setup_ph  = psel & ~penable;
    wire access_ph = psel & penable;
    wire hit_ctrl  = paddr == `LPMC_OFS_CTRL;
    wire hit_stat  = paddr == `LPMC_OFS_STATUS;
    wire hit_cause = paddr == `LPMC_OFS_CAUSE;
    wire mapped    = hit_ctrl | hit_stat | hit_cause;
    wire wr_ctrl   = access_ph & pwrite & hit_ctrl;
    wire wr_cause  = access_ph & pwrite & hit_cause;

    function automatic logic [31:0] rd_mux(
        input logic [`LPMC_ADDR_W-1:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a == `LPMC_OFS_CTRL)
            d[`LPMC_CTRL_W-1:0] = ctrl_reg;
        else if (a == `LPMC_OFS_STATUS)
            d[3:0] = {pwr_reg.sysclk_fast_rc, state_reg};
        else if (a == `LPMC_OFS_CAUSE)
            d[`LPMC_CAUSE_W-1:0] = cause_reg;
        return d;
    endfunction

    assign pready  = 1'b1;
    assign pslverr = access_ph & ~mapped;
    assign prdata  = rdata_reg;

    ////////////////////////////////////////////////////////////////
    // Request and wake decode
    wire in_stop  = state_reg == LPMC_STOP0 || state_reg == LPMC_STOP1
                  || state_reg == LPMC_BAM;
    wire radio_ok = ctrl_reg.range1 & (state_reg == LPMC_STOP0);
    wire [NPERIPH-1:0] auto_mask =
        (state_reg == LPMC_STOP1) ? NPERIPH'(`LPMC_STOP1_MASK)
        : (NPERIPH'(`LPMC_ALL_MASK)
           & ~(NPERIPH'(!radio_ok) << `LPMC_IDX_RADIO));
    // Clock held until the last requester withdraws
    wire sys_req_any = |(sys_clk_req & auto_mask);
    wire kern_any    = |kernel_clk_req;
    wire stop_wake   = irq_pending | periph_irq;

    wire wakeup_pin_edge = ctrl_reg.wakeup_pin_fall
                   ? (wakeup_pin_prev_reg & ~wake_src.wakeup_pin)
                   : (~wakeup_pin_prev_reg & wake_src.wakeup_pin);
    wire [`LPMC_CAUSE_W-1:0] sb_src = {
        1'b0,
        wake_src.radio_timer & ctrl_reg.radio_ret,
        wake_src.tamper_pin | wake_src.tamper_fail,
        wake_src.rtc_event,
        wakeup_pin_edge,
        wake_src.wdg_event,
        wake_src.reset_pin};
    wire sb_wake = (state_reg == LPMC_STANDBY) & (|sb_src);
    wire [`LPMC_CAUSE_W-1:0] cause_set =
        sb_wake ? sb_src
        : {in_stop & stop_wake, {(`LPMC_CAUSE_W-1){1'b0}}};

    ////////////////////////////////////////////////////////////////
    // Mode sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            LPMC_RUN: begin
                if (cpu_lp_req) begin
                    unique case (ctrl_reg.lp_sel)
                        LPMC_SEL_SLEEP:   state_next = LPMC_SLEEP;
                        LPMC_SEL_STOP0:   state_next = LPMC_STOP0;
                        LPMC_SEL_STOP1:   state_next = LPMC_STOP1;
                        LPMC_SEL_STANDBY: state_next = LPMC_STANDBY;
                    endcase
                end
            end
            LPMC_SLEEP: begin
                if (stop_wake)
                    state_next = LPMC_RUN;
            end
            LPMC_STOP0: begin
                if (stop_wake)
                    state_next = LPMC_WAKE;
            end
            LPMC_STOP1: begin
                if (stop_wake)
                    state_next = LPMC_WAKE;
                else if (sys_req_any)
                    state_next = LPMC_BAM;
            end
            LPMC_BAM: begin
                if (stop_wake)
                    state_next = LPMC_WAKE;
                else if (!sys_req_any)
                    state_next = LPMC_STOP1;
            end
            LPMC_STANDBY: begin
                if (sb_wake)
                    state_next = LPMC_WAKE;
            end
            LPMC_WAKE: state_next = LPMC_RUN;
            default:   state_next = LPMC_RUN;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Power, clock and retention controls
    wire st_run   = state_next == LPMC_RUN;
    wire st_awake = st_run || state_next == LPMC_SLEEP;
    wire st_wake  = state_next == LPMC_WAKE;
    wire st_sb    = state_next == LPMC_STANDBY;
    wire st_stop1 = state_next == LPMC_STOP1;
    wire st_s0    = state_next == LPMC_STOP0
                  || state_next == LPMC_BAM;
    wire bus_req  = st_s0 & sys_req_any;
    wire leave_lp = st_wake;

    always_comb begin
        pwr_next = PWR_RUN;
        pwr_next.cpu_clk_en = st_run | st_wake;
        // Core clocks stop in stop and standby
        pwr_next.core_clk_en = st_awake | st_wake;
        pwr_next.bus_clk_en  = st_awake | st_wake | bus_req;
        pwr_next.pll_en = st_awake & ctrl_reg.pll_on;
        pwr_next.fast_crystal_osc_en =
            st_awake & ctrl_reg.xtal_on;
        // Fast RC woken for bus or kernel clock requests
        pwr_next.fast_internal_rc_en = st_awake | st_wake
            | bus_req | ((st_s0 | st_stop1) & kern_any);
        // Fast RC is the clock on any exit from stop or standby
        pwr_next.sysclk_fast_rc = leave_lp
            | (pwr_reg.sysclk_fast_rc & ~ctrl_reg.sysclk_xtal)
            | ~st_awake;
        pwr_next.main_reg_en = st_awake | st_wake | st_s0;
        pwr_next.lp_reg_en   = st_stop1 | (st_sb
            & (ctrl_reg.first_sram_bank_ret | ctrl_reg.second_sram_bank_ret
               | ctrl_reg.radio_ret));
        pwr_next.core_supply_on = ~st_sb;
        // Core domain held in reset while unpowered
        pwr_next.core_rst = st_sb;
        pwr_next.bor_ulp  = ctrl_reg.bor_ulp
                          & (st_stop1 | st_sb);
        pwr_next.io_hold  = st_sb;
        pwr_next.io_pull  = st_sb ? ctrl_reg.io_pull : 2'h0;
        // Stop keeps everything, standby only what is chosen
        pwr_next.first_sram_bank_keep = ~st_sb | ctrl_reg.first_sram_bank_ret;
        pwr_next.second_sram_bank_keep = ~st_sb | ctrl_reg.second_sram_bank_ret;
        pwr_next.radio_keep = ~st_sb | ctrl_reg.radio_ret;
        pwr_next.sleep_timer_en = ~st_sb
                                | ctrl_reg.radio_ret;
        pwr_next.dma_auto_en = st_s0;
        pwr_next.radio_auto_en = (state_next == LPMC_STOP0)
                               & ctrl_reg.range1;
    end

    // Software selection of the crystal is undone by a wake-up
    always_comb begin
        ctrl_next = wr_ctrl ? lpmc_ctrl_type'(pwdata[`LPMC_CTRL_W-1:0])
                            : ctrl_reg;
        if (leave_lp)
            ctrl_next.sysclk_xtal = 1'b0;
    end

    // Event set wins over a write-one clear in the same cycle
    assign cause_next = (cause_reg
                      & ~(wr_cause ? pwdata[`LPMC_CAUSE_W-1:0]
                                   : `LPMC_CAUSE_RST))
                      | cause_set;

    ////////////////////////////////////////////////////////////////
    // Flip-flops; control register lives in the backup domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= LPMC_RUN;
            pwr_reg   <= PWR_RUN;
        end else begin
            state_reg <= state_next;
            pwr_reg   <= pwr_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg      <= lpmc_ctrl_type'(`LPMC_CTRL_RST);
            cause_reg     <= `LPMC_CAUSE_RST;
            rdata_reg     <= 32'h0000_0000;
            kclk_reg      <= '0;
            wakeup_pin_prev_reg <= 1'b0;
        end else begin
            ctrl_reg      <= ctrl_next;
            cause_reg     <= cause_next;
            kclk_reg      <= kernel_clk_req;
            wakeup_pin_prev_reg <= wake_src.wakeup_pin;
            if (setup_ph)
                rdata_reg <= rd_mux(paddr);
        end
    end

    assign kernel_clk_en = kclk_reg;
    assign pwr  = pwr_reg;
    assign mode = state_reg;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_in_stop1_req;
        state_reg == LPMC_STOP1 && !stop_wake && sys_req_any;
    endsequence
    // Controls are registered with the state, so both change together
    sequence s_bam_on;
        state_reg == LPMC_BAM && pwr_reg.bus_clk_en
            && pwr_reg.fast_internal_rc_en && pwr_reg.main_reg_en;
    endsequence

    a_bam_entry: assert property (
        s_in_stop1_req |=> s_bam_on)
        else $error("stop 1 clock request did not reach stop 0");

    a_bam_return: assert property (
        state_reg == LPMC_BAM && !stop_wake && !sys_req_any
        |=> state_reg == LPMC_STOP1 && !pwr_reg.main_reg_en
            && pwr_reg.lp_reg_en && !pwr_reg.bus_clk_en)
        else $error("stop 1 not re-entered after requests ended");

    a_sleep_clk: assert property (
        state_reg == LPMC_SLEEP |-> !pwr_reg.cpu_clk_en
            && pwr_reg.core_clk_en
            && pwr_reg.bus_clk_en)
        else $error("sleep clock gating wrong");

    a_stop_osc_off: assert property (
        (state_reg == LPMC_STOP0 || state_reg == LPMC_STOP1)
        && !stop_wake |=> !pwr_reg.core_clk_en && !pwr_reg.pll_en
            && !pwr_reg.fast_crystal_osc_en)
        else $error("core clocks or oscillators left on in stop");

    a_wake_run: assert property (
        in_stop && stop_wake
        |=> state_reg == LPMC_WAKE ##1 state_reg == LPMC_RUN)
        else $error("stop wake-up did not return to run");

    a_wake_fast_rc: assert property (
        state_reg == LPMC_WAKE |-> pwr_reg.sysclk_fast_rc
            ##1 pwr_reg.sysclk_fast_rc && !ctrl_reg.sysclk_xtal)
        else $error("system clock not fast RC after wake-up");

    a_standby_off: assert property (
        state_reg == LPMC_STANDBY && $past(state_reg) == LPMC_STANDBY
        |-> !pwr_reg.core_supply_on && !pwr_reg.fast_internal_rc_en
            && pwr_reg.core_rst && pwr_reg.io_hold)
        else $error("standby power state wrong");

    a_timer_gate: assert property (
        state_reg == LPMC_STANDBY && !ctrl_reg.radio_ret
        && !(|sb_src[`LPMC_WK_TAMPER:0])
        |=> state_reg == LPMC_STANDBY)
        else $error("radio timer left standby without retention");

    a_bor_ulp: assert property (
        pwr_reg.bor_ulp |-> $past(ctrl_reg.bor_ulp)
            && $past(state_next == LPMC_STOP1
                     || state_next == LPMC_STANDBY))
        else $error("brownout low-power setting outside its modes");

    a_kernel_clk: assert property (
        kernel_clk_req != '0 |=> kernel_clk_en == $past(kernel_clk_req))
        else $error("kernel clock does not follow requests");

    a_kernel_off: assert property (
        kernel_clk_req == '0 |=> kernel_clk_en == '0)
        else $error("kernel clock left on without requests");

    a_stop0_reg: assert property (
        state_reg == LPMC_STOP0 || state_reg == LPMC_BAM
        |-> pwr_reg.main_reg_en && pwr_reg.dma_auto_en)
        else $error("stop 0 regulator or DMA clock missing");

    a_radio_auto: assert property (
        pwr_reg.radio_auto_en |-> state_reg == LPMC_STOP0)
        else $error("radio autonomous outside stop 0");

    a_stop1_refuse: assert property (
        state_reg == LPMC_STOP1 && !stop_wake
        && (sys_clk_req & NPERIPH'(`LPMC_STOP1_MASK)) == '0
        |=> state_reg == LPMC_STOP1)
        else $error("radio or DMA request left stop 1");

    a_standby_exit: assert property (
        state_reg == LPMC_STANDBY
        && (wake_src.reset_pin || wake_src.wdg_event || wake_src.rtc_event)
        |=> state_reg == LPMC_WAKE ##1 state_reg == LPMC_RUN)
        else $error("standby did not exit on a wake source");

endmodule

`default_nettype wire

/* File: design/lpmc_params.svh */
// Purpose: Register map, field positions and constants for the
//          low-power mode controller.
// Assumes: 32-bit APB, one aligned word per register.
// Notes:   Definitions only.
//
// Contract
// - After power-on or system reset the device is in run mode.
// - Sleep halts only the processor clock; any interrupt or event resumes.
// - Stop levels cut core clocks, PLL, fast RC and fast crystal.
// - Stop levels keep SRAM and all register contents.
// - RTC, tamper, watchdog and radio sleep timer may run in stop.
// - Stop level 0 keeps the main regulator on.
// - Leaving a stop level, the system clock is the fast internal RC.
// - Brownout ultra-low-power option applies in stop level 1 and standby.
// - Standby turns the regulator off; PLL and fast oscillators are off.
// - Brownout stays on in standby; RTC and watchdog may run.
// - In standby each pin holds pull-up, pull-down or floating.
// - Entering standby loses SRAM and registers except backup domain.
// - SRAM banks and radio optionally retained in standby by low-power regulator.
// - Standby exits on reset pin, watchdog, wake pin edge, RTC, tamper.
// - Tamper exit comes from external tamper pins or internal failure detector.
// - Radio sleep timer exits standby only with radio retention.
// - After standby wake-up the system clock is the fast internal RC.
// - Listed peripherals and DMA run autonomously in stop 0; radio in range 1.
// - In stop 1 non-radio, non-DMA peripherals may request stop 0.
// - Kernel clock on while requested, off when no request remains.
// - System clock request enters stop 0 and distributes fast RC bus clock.
// - No bus clock request and stop 1 selected: return to stop 1.
// - Autonomous peripherals start on hardware triggers, without the processor.
// - DMA stays fully functional in stop 0, linked list included.
// - Autonomous peripheral interrupt wakes the device from either stop level.
`ifndef LPMC_PARAMS_SVH
`define LPMC_PARAMS_SVH

`define LPMC_ADDR_W      12
`define LPMC_OFS_CTRL    12'h000
`define LPMC_OFS_STATUS  12'h004
`define LPMC_OFS_CAUSE   12'h008
`define LPMC_CTRL_W      13
`define LPMC_CTRL_RST    13'h0000
`define LPMC_CAUSE_W     7
`define LPMC_CAUSE_RST   7'h00
`define LPMC_WK_RSTPIN   0
`define LPMC_WK_WDG      1
`define LPMC_WK_PIN      2
`define LPMC_WK_RTC      3
`define LPMC_WK_TAMPER   4
`define LPMC_WK_RTIMER   5
`define LPMC_WK_PERIPH   6
`define LPMC_NPERIPH     8
`define LPMC_IDX_RADIO   6
`define LPMC_STOP1_MASK  8'h3f
`define LPMC_ALL_MASK    8'hff

`endif

/* File: design/lpmc_pkg.sv */
// Purpose: Types of the low-power mode controller.
// Assumes: Constants come from lpmc_params.svh.
// Notes:   Struct layouts fix the register bit order.
`default_nettype none
package lpmc_pkg;

    typedef enum logic [2:0] {
        LPMC_RUN     = 3'h0,
        LPMC_SLEEP   = 3'h1,
        LPMC_STOP0   = 3'h3,
        LPMC_STOP1   = 3'h2,
        LPMC_BAM     = 3'h6,
        LPMC_STANDBY = 3'h7,
        LPMC_WAKE    = 3'h5
    } lpmc_state_type;

    typedef enum logic [1:0] {
        LPMC_SEL_SLEEP   = 2'h0,
        LPMC_SEL_STOP0   = 2'h1,
        LPMC_SEL_STOP1   = 2'h2,
        LPMC_SEL_STANDBY = 2'h3
    } lpmc_sel_type;

    // Control register, bit 0 at the bottom
    typedef struct packed {
        logic         sysclk_xtal;
        logic         xtal_on;
        logic         pll_on;
        logic         range1;
        logic         wakeup_pin_fall;
        logic [1:0]   io_pull;
        logic         radio_ret;
        logic         second_sram_bank_ret;
        logic         first_sram_bank_ret;
        logic         bor_ulp;
        lpmc_sel_type lp_sel;
    } lpmc_ctrl_type;

    typedef struct packed {
        logic       cpu_clk_en;
        logic       core_clk_en;
        logic       bus_clk_en;
        logic       pll_en;
        logic       fast_internal_rc_en;
        logic       fast_crystal_osc_en;
        logic       sysclk_fast_rc;
        logic       main_reg_en;
        logic       lp_reg_en;
        logic       core_supply_on;
        logic       core_rst;
        logic       bor_ulp;
        logic       io_hold;
        logic [1:0] io_pull;
        logic       first_sram_bank_keep;
        logic       second_sram_bank_keep;
        logic       radio_keep;
        logic       sleep_timer_en;
        logic       dma_auto_en;
        logic       radio_auto_en;
    } lpmc_pwr_type;

    typedef struct packed {
        logic reset_pin;
        logic wdg_event;
        logic wakeup_pin;
        logic rtc_event;
        logic tamper_pin;
        logic tamper_fail;
        logic radio_timer;
    } lpmc_wake_type;

endpackage
`default_nettype wire

/* File: test/lpmc_periph_model.sv */
// Purpose: Autonomous peripherals asking for kernel and bus clocks.
// Assumes: A trigger bit starts a job that lasts len cycles.
// Notes:   Jobs need no processor; requests are pure hardware.
`timescale 1ns/1ps
`default_nettype none
module lpmc_periph_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] trig,
    input  wire logic [3:0] len,
    output logic      [7:0] kernel_clk_req,
    output logic      [7:0] sys_clk_req
);
    logic [3:0] cnt_reg [8];
    // A hardware trigger starts the job at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++)
                cnt_reg[i] <= 4'h0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (trig[i])
                    cnt_reg[i] <= len;
                else if (cnt_reg[i] != 4'h0)
                    cnt_reg[i] <= cnt_reg[i] - 4'h1;
            end
        end
    end
    // Busy units ask for both clocks, also from stop 1
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            kernel_clk_req[i] = (cnt_reg[i] != 4'h0);
            sys_clk_req[i]    = (cnt_reg[i] != 4'h0);
        end
    end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Purpose: Self-checking bench of the low-power mode controller.
// Assumes: Zero-wait APB; mode moves one edge after its cause.
// Notes:   Clock requests come from lpmc_periph_model.
`include "lpmc_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
    n_mismatch++; $display("ERROR %0t got %0h exp %0h", $time, a, e); end end
module tb;
    import lpmc_pkg::*;
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [11:0]    paddr = 12'h000;
    logic [31:0]    pwdata = 32'h0;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           cpu_lp_req = 1'b0;
    logic           irq_pending = 1'b0;
    logic           periph_irq = 1'b0;
    logic [7:0]     kernel_clk_req;
    logic [7:0]     sys_clk_req;
    lpmc_wake_type  wake_src = '0;
    logic [7:0]     kernel_clk_en;
    lpmc_pwr_type   pwr;
    lpmc_state_type mode;
    logic [7:0]     trig = 8'h00;
    logic [3:0]     len = 4'h0;
    logic [31:0]    rd;
    logic           err;
    int             n_mismatch = 0;
    int             cmp_count = 0;

    lpmc_controller #(.NPERIPH(8)) i_lpmc_controller (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cpu_lp_req, .irq_pending, .periph_irq, .kernel_clk_req,
        .sys_clk_req, .wake_src, .kernel_clk_en, .pwr, .mode);
    lpmc_periph_model i_lpmc_periph_model (.pclk, .presetn, .trig, .len,
        .kernel_clk_req, .sys_clk_req);

    always #2.5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_mode(input lpmc_state_type m);
        int n;
        n = 0;
        while (mode !== m && n < 10) begin
            @(posedge pclk);
            #1;
            n++;
        end
        `CHK(mode, m)
    endtask

    task automatic lp_enter(input logic [31:0] ctrl);
        apb(1'b1, `LPMC_OFS_CTRL, ctrl);
        @(posedge pclk);
        cpu_lp_req <= 1'b1;
        @(posedge pclk);
        cpu_lp_req <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK(mode, LPMC_RUN)
        `CHK({pwr.cpu_clk_en, pwr.pll_en, kernel_clk_en}, 10'h200)
        apb(1'b0, `LPMC_OFS_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, `LPMC_OFS_STATUS, 32'hf);
        apb(1'b0, `LPMC_OFS_STATUS, 32'h0);
        `CHK(rd, 32'h8)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        apb(1'b1, `LPMC_OFS_CTRL, 32'hffffffff);
        apb(1'b0, `LPMC_OFS_CTRL, 32'h0);
        `CHK(rd, 32'h1fff)
    endtask

    task automatic t_sleep();
        lp_enter(32'h0);
        wait_mode(LPMC_SLEEP);
        `CHK({pwr.cpu_clk_en, pwr.core_clk_en, pwr.bus_clk_en}, 3'h3)
        @(posedge pclk);
        irq_pending <= 1'b1;
        wait_mode(LPMC_RUN);
        @(posedge pclk);
        irq_pending <= 1'b0;
    endtask

    task automatic t_stop0();
        lp_enter(32'h201);
        wait_mode(LPMC_STOP0);
        `CHK({pwr.pll_en, pwr.fast_crystal_osc_en, pwr.core_clk_en}, 3'h0)
        `CHK(pwr.main_reg_en, 1'b1)
        @(posedge pclk);
        trig <= 8'h40;
        len <= 4'h6;
        @(posedge pclk);
        trig <= 8'h00;
        repeat (3) @(posedge pclk);
        #1;
        `CHK({pwr.bus_clk_en, pwr.fast_internal_rc_en}, 2'h3)
        `CHK({pwr.dma_auto_en, pwr.radio_auto_en}, 2'h3)
        @(posedge pclk);
        irq_pending <= 1'b1;
        wait_mode(LPMC_WAKE);
        `CHK(pwr.sysclk_fast_rc, 1'b1)
        @(posedge pclk);
        irq_pending <= 1'b0;
        wait_mode(LPMC_RUN);
        apb(1'b0, `LPMC_OFS_CTRL, 32'h0);
        `CHK(rd, 32'h201)
        apb(1'b0, `LPMC_OFS_CAUSE, 32'h0);
        `CHK(rd[6], 1'b1)
        apb(1'b1, `LPMC_OFS_CAUSE, 32'h7f);
    endtask

    task automatic t_bam();
        lp_enter(32'h6);
        wait_mode(LPMC_STOP1);
        `CHK({pwr.bor_ulp, pwr.lp_reg_en, pwr.main_reg_en}, 3'h6)
        @(posedge pclk);
        trig <= 8'h40;
        len <= 4'h6;
        @(posedge pclk);
        trig <= 8'h00;
        repeat (4) @(posedge pclk);
        #1;
        `CHK({mode, kernel_clk_en[6]}, {LPMC_STOP1, 1'b1})
        repeat (6) @(posedge pclk);
        trig <= 8'h01;
        len <= 4'h3;
        @(posedge pclk);
        trig <= 8'h08;
        len <= 4'h9;
        @(posedge pclk);
        trig <= 8'h00;
        wait_mode(LPMC_BAM);
        `CHK({pwr.bus_clk_en, pwr.fast_internal_rc_en}, 2'h3)
        `CHK({pwr.main_reg_en, pwr.dma_auto_en, pwr.radio_auto_en}, 3'h6)
        repeat (5) @(posedge pclk);
        #1;
        `CHK({mode, kernel_clk_en}, {LPMC_BAM, 8'h08})
        wait_mode(LPMC_STOP1);
        `CHK({pwr.bus_clk_en, kernel_clk_en}, 9'h0)
        @(posedge pclk);
        periph_irq <= 1'b1;
        wait_mode(LPMC_WAKE);
        @(posedge pclk);
        periph_irq <= 1'b0;
        wait_mode(LPMC_RUN);
    endtask

    task automatic standby_trip(input logic [31:0] ctrl, input logic [6:0] pre,
                                input logic [6:0] src, input logic [6:0] cause);
        apb(1'b1, `LPMC_OFS_CAUSE, 32'h7f);
        lp_enter(ctrl);
        wait_mode(LPMC_STANDBY);
        `CHK({pwr.core_supply_on, pwr.core_rst, pwr.pll_en}, 3'h2)
        `CHK({pwr.io_hold, pwr.io_pull}, 3'h6)
        `CHK({pwr.bor_ulp, pwr.radio_keep}, {ctrl[2], ctrl[5]})
        `CHK({pwr.sleep_timer_en, pwr.second_sram_bank_keep, pwr.first_sram_bank_keep},
             ctrl[5:3])
        `CHK(pwr.lp_reg_en, |ctrl[5:3])
        @(posedge pclk);
        wake_src <= pre;
        repeat (4) @(posedge pclk);
        #1;
        `CHK(mode, LPMC_STANDBY)
        @(posedge pclk);
        wake_src <= src;
        wait_mode(LPMC_WAKE);
        `CHK(pwr.sysclk_fast_rc, 1'b1)
        @(posedge pclk);
        wake_src <= '0;
        wait_mode(LPMC_RUN);
        apb(1'b0, `LPMC_OFS_CAUSE, 32'h0);
        `CHK(rd[6:0], cause)
    endtask

    task automatic t_standby();
        standby_trip(32'h87, 7'h00, 7'h40, 7'h01);
        standby_trip(32'h87, 7'h00, 7'h20, 7'h02);
        standby_trip(32'h87, 7'h00, 7'h10, 7'h04);
        standby_trip(32'h9b, 7'h00, 7'h08, 7'h08);
        standby_trip(32'h87, 7'h00, 7'h04, 7'h10);
        standby_trip(32'h87, 7'h00, 7'h02, 7'h10);
        standby_trip(32'h87, 7'h01, 7'h09, 7'h08);
        standby_trip(32'ha7, 7'h00, 7'h01, 7'h20);
        standby_trip(32'h187, 7'h10, 7'h00, 7'h04);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        t_reset();
        t_sleep();
        t_stop0();
        t_bam();
        t_standby();
        give_verdict();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #20000;
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
